// ==== dss_pkg.sv ====
package dss_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFS_ACC = 8'h00;
  localparam logic [7:0] OFS_FUNC = 8'h04;
  localparam logic [7:0] OFS_XFER_CNT = 8'h08;
  localparam logic [7:0] OFS_MADDR0 = 8'h0c;
  localparam logic [7:0] OFS_MADDR1 = 8'h10;
  localparam logic [7:0] OFS_PCNT0 = 8'h14;
  localparam logic [7:0] OFS_PCNT1 = 8'h18;
  localparam logic [7:0] OFS_BUSCTL = 8'h1c;
  localparam logic [7:0] OFS_SEQSTART = 8'h20;
  localparam logic [7:0] OFS_FLAGS = 8'h24;
  localparam logic [7:0] OFS_ENDSTAT = 8'h28;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h2c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h30;

  // function register layout and codes
  localparam int FN_CODE_LSB = 0;
  localparam int FN_CODE_W = 5;
  localparam int FN_CHAN_BIT = 8;
  localparam logic [4:0] FN_CLEAR_FLAGS = 5'h00;
  localparam logic [4:0] FN_START_SEQ = 5'h01;
  localparam logic [4:0] FN_LOAD_XFER = 5'h04;
  localparam logic [4:0] FN_LOAD_MADDR = 5'h0e;
  localparam logic [4:0] FN_LOAD_PCNT = 5'h0f;
  localparam logic [4:0] FN_LOAD_BUSCTL = 5'h10;
  localparam logic CHAN_ODD = 1'h1;

  // sequence start field layout
  localparam int SQ_W = 7;
  localparam int AUX_LSB = 8;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;

  // status bits, shared by status and mask registers
  localparam int IRQ_W = 2;
  localparam int IRQ_SEQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;

  // flags register layout
  localparam int FLG_BUSY_LSB = 0;
  localparam int FLG_DONE_LSB = 2;
  localparam int FLG_RUN = 4;
  localparam int FLG_SLAVE_ACK = 5;

  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_BUSCTL,
    SEQ_FETCH,
    SEQ_XFER,
    SEQ_STATUS
  } dss_seq_t;

  // outgoing parallel bus bundle
  typedef struct packed {
    logic [15:0] data;
    logic strobe;
    logic busctl;
    logic read;
  } dss_link_t;

  // local memory read request bundle
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
  } dss_mem_req_t;

endpackage

// ==== dss_interlock.sv ====
`timescale 1ns/10ps
// one fully interlocked strobe/acknowledge exchange
module dss_interlock (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  input wire logic ack_i,
  output logic strobe_o,
  output logic done_o
);

  typedef enum logic [1:0] {
    IL_IDLE,
    IL_WAIT_ACK,
    IL_WAIT_REL
  } dss_il_t;

  dss_il_t st_q;

  // strobe held until ack, then wait for ack to fall before the next
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= IL_IDLE;
      strobe_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (st_q)
        IL_IDLE: begin
          if (start_i) begin
            st_q <= IL_WAIT_ACK;
            strobe_o <= 1'b1;
          end
        end
        IL_WAIT_ACK: begin
          if (ack_i) begin
            st_q <= IL_WAIT_REL;
            strobe_o <= 1'b0;
          end
        end
        default: begin
          if (!ack_i) begin
            st_q <= IL_IDLE;
            done_o <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule

// ==== dss_seek_seq.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - clear-flags clears busy and done of its channel; host uses both.
// - load-transfer-count copies the 16-bit accumulator into the transfer counter.
// - load-memory-address copies the accumulator into the channel memory address.
// - load-parcel-count copies the accumulator into the channel parcel count.
// - load-bus-control writes bits 0-7 low register, bits 8-15 high register.
// - start on odd channel runs bus control, transfer unless the transfer counter is zero, then ending status.
// - after the sequences the link rests in slave acknowledge, not idle.
module dss_seek_seq (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // local memory parcel fetch
  output dss_pkg::dss_mem_req_t MEM_REQ_O,
  input wire logic [15:0] MEM_RDATA_I,
  input wire logic MEM_RVALID_I,
  // parallel disk bus
  output dss_pkg::dss_link_t LINK_O,
  input wire logic LINK_ACK_I,
  input wire logic [15:0] LINK_DATA_I,
  output logic LINK_SLAVE_ACK_O,
  // interrupt
  output logic IRQ_O
);

  // register state
  logic [15:0] acc_q;
  logic [15:0] xfer_cnt_q;
  logic [15:0] maddr_q [2];
  logic [15:0] pcnt_q [2];
  logic [7:0] bc_lo_q;
  logic [7:0] bc_hi_q;
  logic [6:0] sq_q;
  logic [7:0] aux_q;
  logic [1:0] busy_q;
  logic [1:0] done_q;
  logic [15:0] endstat_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [31:0] prdata_q;
  logic slave_ack_q;

  // sequencer state
  dss_pkg::dss_seq_t seq_q;
  logic kick_q;
  logic mem_rd_q;
  logic [15:0] link_data_q;
  logic il_strobe;
  logic il_done;

  // decode of the apb address, used for write and error; the read mux decodes on its own
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == dss_pkg::OFS_ACC) || (a == dss_pkg::OFS_FUNC) ||
                (a == dss_pkg::OFS_XFER_CNT) || (a == dss_pkg::OFS_MADDR0) ||
                (a == dss_pkg::OFS_MADDR1) || (a == dss_pkg::OFS_PCNT0) ||
                (a == dss_pkg::OFS_PCNT1) || (a == dss_pkg::OFS_BUSCTL) ||
                (a == dss_pkg::OFS_SEQSTART) || (a == dss_pkg::OFS_FLAGS) ||
                (a == dss_pkg::OFS_ENDSTAT) || (a == dss_pkg::OFS_IRQ_STAT) ||
                (a == dss_pkg::OFS_IRQ_MASK);
  endfunction

  // apb strobes; every access completes in its first access cycle
  wire logic access = PSEL_I && PENABLE_I;
  wire logic setup = PSEL_I && !PENABLE_I;
  wire logic wr = access && PWRITE_I && is_mapped(PADDR_I);
  wire logic wr_acc = wr && (PADDR_I == dss_pkg::OFS_ACC);
  wire logic wr_func = wr && (PADDR_I == dss_pkg::OFS_FUNC);
  wire logic wr_istat = wr && (PADDR_I == dss_pkg::OFS_IRQ_STAT);
  wire logic wr_imask = wr && (PADDR_I == dss_pkg::OFS_IRQ_MASK);

  // function decode
  wire logic [4:0] fn_code = PWDATA_I[dss_pkg::FN_CODE_LSB +: dss_pkg::FN_CODE_W];
  wire logic fn_chan = PWDATA_I[dss_pkg::FN_CHAN_BIT];
  wire logic running = (seq_q != dss_pkg::SEQ_IDLE);
  wire logic fn_clear = wr_func && (fn_code == dss_pkg::FN_CLEAR_FLAGS);
  wire logic fn_start = wr_func && (fn_code == dss_pkg::FN_START_SEQ);
  wire logic fn_load = wr_func && ((fn_code == dss_pkg::FN_LOAD_XFER) ||
                       (fn_code == dss_pkg::FN_LOAD_MADDR) ||
                       (fn_code == dss_pkg::FN_LOAD_PCNT) ||
                       (fn_code == dss_pkg::FN_LOAD_BUSCTL));
  // loads are ignored while a sequence runs, so its parameters stay fixed
  wire logic load_ok = fn_load && !running;
  wire logic start_ok = fn_start && !running && (fn_chan == dss_pkg::CHAN_ODD);
  wire logic fn_bad = (fn_load && running) || (fn_start && !start_ok) ||
                      (wr_func && !fn_load && !fn_start && !fn_clear);
  wire logic ld_xfer = load_ok && (fn_code == dss_pkg::FN_LOAD_XFER);
  wire logic ld_maddr = load_ok && (fn_code == dss_pkg::FN_LOAD_MADDR);
  wire logic ld_pcnt = load_ok && (fn_code == dss_pkg::FN_LOAD_PCNT);
  wire logic ld_bc = load_ok && (fn_code == dss_pkg::FN_LOAD_BUSCTL);

  // sequencer progress events
  wire logic parcel_sent = (seq_q == dss_pkg::SEQ_XFER) && il_done;
  wire logic seq_end = (seq_q == dss_pkg::SEQ_STATUS) && il_done;
  wire logic last_parcel = (xfer_cnt_q == dss_pkg::ONE16);

  // read mux
  wire logic [31:0] rd_mux =
    (PADDR_I == dss_pkg::OFS_ACC) ? {16'h0000, acc_q} :
    (PADDR_I == dss_pkg::OFS_XFER_CNT) ? {16'h0000, xfer_cnt_q} :
    (PADDR_I == dss_pkg::OFS_MADDR0) ? {16'h0000, maddr_q[0]} :
    (PADDR_I == dss_pkg::OFS_MADDR1) ? {16'h0000, maddr_q[1]} :
    (PADDR_I == dss_pkg::OFS_PCNT0) ? {16'h0000, pcnt_q[0]} :
    (PADDR_I == dss_pkg::OFS_PCNT1) ? {16'h0000, pcnt_q[1]} :
    (PADDR_I == dss_pkg::OFS_BUSCTL) ? {16'h0000, bc_hi_q, bc_lo_q} :
    (PADDR_I == dss_pkg::OFS_SEQSTART) ? {16'h0000, aux_q, 1'b0, sq_q} :
    (PADDR_I == dss_pkg::OFS_FLAGS) ?
      {26'h0000000, slave_ack_q, running, done_q, busy_q} :
    (PADDR_I == dss_pkg::OFS_ENDSTAT) ? {16'h0000, endstat_q} :
    (PADDR_I == dss_pkg::OFS_IRQ_STAT) ? {30'h00000000, irq_stat_q} :
    (PADDR_I == dss_pkg::OFS_IRQ_MASK) ? {30'h00000000, irq_mask_q} :
    dss_pkg::ZERO32;

  // apb answer: zero wait states, error on unmapped offsets
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access && !is_mapped(PADDR_I);
  assign PRDATA_O = prdata_q;

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      prdata_q <= dss_pkg::ZERO32;
    end else if (setup && !PWRITE_I) begin
      prdata_q <= rd_mux;
    end
  end

  // accumulator, bus control and sequence start registers
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      acc_q <= dss_pkg::ZERO16;
      bc_lo_q <= 8'h00;
      bc_hi_q <= 8'h00;
      sq_q <= 7'h00;
      aux_q <= 8'h00;
    end else begin
      if (wr_acc) begin
        acc_q <= PWDATA_I[dss_pkg::WORD_W-1:0];
      end
      if (ld_bc) begin
        bc_lo_q <= acc_q[dss_pkg::BYTE_W-1:0];
        bc_hi_q <= acc_q[dss_pkg::WORD_W-1:dss_pkg::BYTE_W];
      end
      if (start_ok) begin
        sq_q <= acc_q[dss_pkg::SQ_W-1:0];
        aux_q <= acc_q[dss_pkg::WORD_W-1:dss_pkg::AUX_LSB];
      end
    end
  end

  // transfer counter: loaded by function, counted down per parcel
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      xfer_cnt_q <= dss_pkg::ZERO16;
    end else if (ld_xfer) begin
      xfer_cnt_q <= acc_q;
    end else if (parcel_sent) begin
      xfer_cnt_q <= xfer_cnt_q - dss_pkg::ONE16;
    end
  end

  // per channel address, parcel count and flags
  for (genvar c = 0; c < 2; c++) begin : g_chan
    wire logic is_odd = (1'(c) == dss_pkg::CHAN_ODD);
    wire logic sel = (fn_chan == 1'(c));
    wire logic act = is_odd && parcel_sent;

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        maddr_q[c] <= dss_pkg::ZERO16;
        pcnt_q[c] <= dss_pkg::ZERO16;
      end else begin
        if (ld_maddr && sel) begin
          maddr_q[c] <= acc_q;
        end else if (act) begin
          maddr_q[c] <= maddr_q[c] + dss_pkg::ONE16;
        end
        if (ld_pcnt && sel) begin
          pcnt_q[c] <= acc_q;
        end else if (act && (pcnt_q[c] != dss_pkg::ZERO16)) begin
          pcnt_q[c] <= pcnt_q[c] - dss_pkg::ONE16;
        end
      end
    end

    // busy set by start, done set at sequence end; sets win over clear
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        busy_q[c] <= 1'b0;
        done_q[c] <= 1'b0;
      end else begin
        if (start_ok && sel) begin
          busy_q[c] <= 1'b1;
        end else if ((seq_end && is_odd) || (fn_clear && sel)) begin
          busy_q[c] <= 1'b0;
        end
        // a load marks only the channel it names; bus control is channel-less
        if ((seq_end && is_odd) ||
            (load_ok && (fn_code != dss_pkg::FN_LOAD_BUSCTL) && sel)) begin
          done_q[c] <= 1'b1;
        end else if (fn_clear && sel) begin
          done_q[c] <= 1'b0;
        end
      end
    end
  end

  // sequencer: bus control, interlocked parcels, ending status
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      seq_q <= dss_pkg::SEQ_IDLE;
      kick_q <= 1'b0;
      mem_rd_q <= 1'b0;
      link_data_q <= dss_pkg::ZERO16;
    end else begin
      kick_q <= 1'b0;
      case (seq_q)
        dss_pkg::SEQ_IDLE: begin
          if (start_ok) begin
            seq_q <= dss_pkg::SEQ_BUSCTL;
            link_data_q <= {bc_hi_q, bc_lo_q};
            kick_q <= 1'b1;
          end
        end
        dss_pkg::SEQ_BUSCTL: begin
          if (il_done && xfer_cnt_q == dss_pkg::ZERO16) begin
            seq_q <= dss_pkg::SEQ_STATUS;
            link_data_q <= dss_pkg::ZERO16;
            kick_q <= 1'b1;
          end else if (il_done) begin
            seq_q <= dss_pkg::SEQ_FETCH;
            mem_rd_q <= 1'b1;
          end
        end
        dss_pkg::SEQ_FETCH: begin
          if (MEM_RVALID_I) begin
            seq_q <= dss_pkg::SEQ_XFER;
            link_data_q <= MEM_RDATA_I;
            mem_rd_q <= 1'b0;
            kick_q <= 1'b1;
          end
        end
        dss_pkg::SEQ_XFER: begin
          if (il_done && last_parcel) begin
            seq_q <= dss_pkg::SEQ_STATUS;
            link_data_q <= dss_pkg::ZERO16;
            kick_q <= 1'b1;
          end else if (il_done) begin
            seq_q <= dss_pkg::SEQ_FETCH;
            mem_rd_q <= 1'b1;
          end
        end
        default: begin
          if (il_done) begin
            seq_q <= dss_pkg::SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // ending status captured when the drive acknowledges
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      endstat_q <= dss_pkg::ZERO16;
    end else if (seq_q == dss_pkg::SEQ_STATUS && il_strobe && LINK_ACK_I) begin
      endstat_q <= LINK_DATA_I;
    end
  end

  // link rests in slave acknowledge after the sequences; only a new
  // start leaves it, returning to idle belongs to other routines
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      slave_ack_q <= 1'b0;
    end else if (seq_end) begin
      slave_ack_q <= 1'b1;
    end else if (start_ok) begin
      slave_ack_q <= 1'b0;
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
    end else begin
      irq_stat_q[dss_pkg::IRQ_SEQ_DONE] <= seq_end ||
        (irq_stat_q[dss_pkg::IRQ_SEQ_DONE] && !(wr_istat && PWDATA_I[dss_pkg::IRQ_SEQ_DONE]));
      irq_stat_q[dss_pkg::IRQ_REFUSED] <= fn_bad ||
        (irq_stat_q[dss_pkg::IRQ_REFUSED] && !(wr_istat && PWDATA_I[dss_pkg::IRQ_REFUSED]));
      if (wr_imask) begin
        irq_mask_q <= PWDATA_I[dss_pkg::IRQ_W-1:0];
      end
    end
  end

  assign IRQ_O = |(irq_stat_q & irq_mask_q);

  // strobe handshake shared by all three sequences
  dss_interlock u_interlock (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .start_i(kick_q),
    .ack_i(LINK_ACK_I),
    .strobe_o(il_strobe),
    .done_o(il_done)
  );

  // outputs
  assign MEM_REQ_O.addr = maddr_q[dss_pkg::CHAN_ODD];
  assign MEM_REQ_O.rd = mem_rd_q;
  assign LINK_O.data = link_data_q;
  assign LINK_O.strobe = il_strobe;
  assign LINK_O.busctl = (seq_q == dss_pkg::SEQ_BUSCTL);
  assign LINK_O.read = (seq_q == dss_pkg::SEQ_STATUS);
  assign LINK_SLAVE_ACK_O = slave_ack_q;

endmodule

// ==== dss_seek_seq_asserts.sv ====
`timescale 1ns/10ps
module dss_seek_seq_asserts (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // local memory
  input wire dss_pkg::dss_mem_req_t MEM_REQ_O,
  input wire logic [15:0] MEM_RDATA_I,
  input wire logic MEM_RVALID_I,
  // disk bus
  input wire dss_pkg::dss_link_t LINK_O,
  input wire logic LINK_ACK_I,
  input wire logic [15:0] LINK_DATA_I,
  input wire logic LINK_SLAVE_ACK_O,
  // interrupt
  input wire logic IRQ_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic busy_q;
  // function write decode
  wire fn_wr = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == dss_pkg::OFS_FUNC;
  wire start_wr = fn_wr && PWDATA_I[4:0] == dss_pkg::FN_START_SEQ;
  wire odd = PWDATA_I[dss_pkg::FN_CHAN_BIT];
  // run tracker, so refused starts during a run are not mistaken for accepted ones
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) busy_q <= 1'b0;
    else if (LINK_O.busctl) busy_q <= 1'b1;
    else if (LINK_SLAVE_ACK_O) busy_q <= 1'b0;
  end
  property p_start_runs; start_wr && odd && !busy_q |-> ##[1:2] LINK_O.busctl ##[1:2] LINK_O.strobe; endproperty
  a_start_runs: assert property (p_start_runs) else $error("start did not open bus control");
  property p_even_refused; start_wr && !odd && !busy_q |=> !LINK_O.busctl [*3]; endproperty
  a_even_refused: assert property (p_even_refused) else $error("even start ran");
  property p_ctl_first; LINK_O.busctl |-> !MEM_REQ_O.rd && !LINK_O.read; endproperty
  a_ctl_first: assert property (p_ctl_first) else $error("phases overlap");
  property p_strobe_hold; LINK_O.strobe && !LINK_ACK_I |=> LINK_O.strobe; endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("strobe left early");
  property p_strobe_drop; LINK_O.strobe && LINK_ACK_I |-> ##[1:2] !LINK_O.strobe; endproperty
  a_strobe_drop: assert property (p_strobe_drop) else $error("strobe stuck");
  property p_strobe_rise; $rose(LINK_O.strobe) |-> !LINK_ACK_I; endproperty
  a_strobe_rise: assert property (p_strobe_rise) else $error("strobe before ack low");
  property p_fetch_hold; MEM_REQ_O.rd && !MEM_RVALID_I |=> MEM_REQ_O.rd && $stable(MEM_REQ_O.addr); endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch request dropped");
  property p_rest; LINK_SLAVE_ACK_O && !start_wr && !$past(start_wr) |=> LINK_SLAVE_ACK_O; endproperty
  a_rest: assert property (p_rest) else $error("link left slave ack");
  property p_end_rest; $fell(LINK_O.read) |-> LINK_SLAVE_ACK_O && !LINK_O.busctl; endproperty
  a_end_rest: assert property (p_end_rest) else $error("status end not resting");
  property p_irq; $rose(IRQ_O) |-> $past(PSEL_I && PWRITE_I) || $past(LINK_O.read); endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");
  // main scenarios reached
  c_start: cover property (start_wr && odd && !busy_q);
  c_rest: cover property ($rose(LINK_SLAVE_ACK_O));
  c_irq: cover property ($rose(IRQ_O));
  c_err: cover property (PSLVERR_O);
endmodule
bind dss_seek_seq dss_seek_seq_asserts u_chk (
  .REF_CLK_I, .SYS_RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O,
  .PREADY_O, .PSLVERR_O, .MEM_REQ_O, .MEM_RDATA_I, .MEM_RVALID_I, .LINK_O, .LINK_ACK_I,
  .LINK_DATA_I, .LINK_SLAVE_ACK_O, .IRQ_O
);

// ==== dss_drive_model.sv ====
`timescale 1ns/10ps
module dss_drive_model #(
  parameter logic [15:0] STAT_WORD = 16'h2c01
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // disk bus, drive side
  input wire dss_pkg::dss_link_t link_i,
  input wire logic slow_i,
  output logic ack_o,
  output logic [15:0] data_o
);
  logic [16:0] words [$];
  int cnt;
  // ack follows strobe after a settable delay; each word taken is logged
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      data_o <= 16'h0000;
      cnt <= 0;
    end else begin
      // status only while asked for, otherwise the lines keep moving
      data_o <= (link_i.read && link_i.strobe) ? STAT_WORD : ~data_o;
      if (link_i.strobe === ack_o) begin
        cnt <= 0;
      end else if (cnt < (slow_i ? 3 : 0)) begin
        cnt <= cnt + 1;
      end else begin
        cnt <= 0;
        ack_o <= link_i.strobe;
        if (link_i.strobe) begin
          words.push_back({link_i.read, link_i.data});
        end
      end
    end
  end
endmodule

// ==== dss_seek_seq_tb_top.sv ====
`timescale 1ns/10ps
module dss_seek_seq_tb_top;
  localparam logic [15:0] STAT_WORD = 16'h2c01; // arbitrary drive status
  typedef struct packed {
    logic [4:0] fn;
    logic ch;
    logic [15:0] acc;
    logic [7:0] ofs;
    logic [31:0] exp;
  } dss_row_t;
  logic REF_CLK_I = 1'b0;
  logic SYS_RST_I;
  logic PSEL_I = 1'b0;
  logic PENABLE_I = 1'b0;
  logic PWRITE_I = 1'b0;
  logic [7:0] PADDR_I = 8'h00;
  logic [31:0] PWDATA_I = 32'h0000_0000;
  logic [31:0] PRDATA_O;
  logic PREADY_O;
  logic PSLVERR_O;
  dss_pkg::dss_mem_req_t MEM_REQ_O;
  logic [15:0] MEM_RDATA_I = 16'h0000;
  logic MEM_RVALID_I = 1'b0;
  dss_pkg::dss_link_t LINK_O;
  logic LINK_ACK_I;
  logic [15:0] LINK_DATA_I;
  logic LINK_SLAVE_ACK_O;
  logic IRQ_O;
  logic slow = 1'b0;
  logic [15:0] mem [0:1];
  logic [31:0] r;
  logic e;
  int num_errors = 0;
  int n_compared = 0;
  dss_row_t rows [0:9];
  logic [16:0] wexp [0:5];

  always #2 REF_CLK_I = ~REF_CLK_I;

  dss_seek_seq dut (
    .REF_CLK_I, .SYS_RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O,
    .PREADY_O, .PSLVERR_O, .MEM_REQ_O, .MEM_RDATA_I, .MEM_RVALID_I, .LINK_O, .LINK_ACK_I,
    .LINK_DATA_I, .LINK_SLAVE_ACK_O, .IRQ_O
  );
  dss_drive_model #(.STAT_WORD(STAT_WORD)) drv (.clk_i(REF_CLK_I), .rst_i(SYS_RST_I),
    .link_i(LINK_O), .slow_i(slow), .ack_o(LINK_ACK_I), .data_o(LINK_DATA_I));

  // local memory answers a cycle after each fetch; idle data keeps moving
  always @(posedge REF_CLK_I) begin
    MEM_RVALID_I <= MEM_REQ_O.rd && !MEM_RVALID_I;
    MEM_RDATA_I <= (MEM_REQ_O.rd && !MEM_RVALID_I) ? mem[MEM_REQ_O.addr[0]] : ~MEM_RDATA_I;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; an idle edge first keeps drives one per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge REF_CLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge REF_CLK_I); while (PREADY_O !== 1'b1);
    r = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask

  task automatic rest;
    while (LINK_SLAVE_ACK_O !== 1'b1) @(posedge REF_CLK_I);
  endtask

  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // watchdog, well beyond the expected run length
  initial begin
    repeat (20000) @(posedge REF_CLK_I);
    num_errors++;
    summarize();
  end

  initial begin
    SYS_RST_I = 1'b1;
    // drive counts as selected: the select routine runs before this bench
    mem[0] = 16'h0000; // first seek parcel all zeros
    mem[1] = 16'h1234; // target cylinder
    rows[0] = '{dss_pkg::FN_LOAD_MADDR, 1'b0, 16'h0200, dss_pkg::OFS_MADDR0, 32'h200};
    rows[1] = '{dss_pkg::FN_LOAD_PCNT, 1'b0, 16'h0003, dss_pkg::OFS_PCNT0, 32'h3};
    rows[2] = '{dss_pkg::FN_LOAD_XFER, 1'b0, 16'h1234, dss_pkg::OFS_XFER_CNT, 32'h1234};
    rows[3] = '{dss_pkg::FN_LOAD_BUSCTL, 1'b1, 16'habcd, dss_pkg::OFS_BUSCTL, 32'habcd};
    // only channel 0 was loaded, so clearing it must leave no done flag
    rows[4] = '{dss_pkg::FN_CLEAR_FLAGS, 1'b0, 16'h0000, dss_pkg::OFS_FLAGS, 32'h0};
    rows[5] = '{dss_pkg::FN_CLEAR_FLAGS, 1'b1, 16'h0000, dss_pkg::OFS_FLAGS, 32'h0};
    rows[6] = '{dss_pkg::FN_LOAD_XFER, 1'b1, 16'h0002, dss_pkg::OFS_XFER_CNT, 32'h2};
    // memory address points at the first seek parcel
    rows[7] = '{dss_pkg::FN_LOAD_MADDR, 1'b1, 16'h0100, dss_pkg::OFS_MADDR1, 32'h100};
    rows[8] = '{dss_pkg::FN_LOAD_PCNT, 1'b1, 16'h0002, dss_pkg::OFS_PCNT1, 32'h2};
    // load-cylinder code: low byte with only bit 2 set
    rows[9] = '{dss_pkg::FN_LOAD_BUSCTL, 1'b1, 16'h0004, dss_pkg::OFS_BUSCTL, 32'h4};
    wexp = '{17'h00004, 17'h00000, 17'h01234, 17'h10000, 17'h00004, 17'h10000};
    repeat (12) @(posedge REF_CLK_I);
    SYS_RST_I <= 1'b0;
    chk({31'h0, PREADY_O}, 32'h1);
    apb(1'b0, dss_pkg::OFS_FLAGS, 32'h0);
    chk(r, 32'h0);
    // load and clear-flags functions, each followed by a readback
    foreach (rows[i]) begin
      apb(1'b1, dss_pkg::OFS_ACC, {16'h0000, rows[i].acc});
      apb(1'b1, dss_pkg::OFS_FUNC, {23'h0, rows[i].ch, 3'h0, rows[i].fn});
      apb(1'b0, rows[i].ofs, 32'h0);
      chk(r, rows[i].exp);
    end
    // seek run; bit 7 of the start word set to show it is dropped
    apb(1'b1, dss_pkg::OFS_ACC, 32'h0000_0584); // start address 04, aux 05
    apb(1'b1, dss_pkg::OFS_FUNC, 32'h0000_0101);
    rest();
    apb(1'b0, dss_pkg::OFS_SEQSTART, 32'h0);
    chk(r, 32'h0000_0504);
    apb(1'b0, dss_pkg::OFS_XFER_CNT, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, dss_pkg::OFS_MADDR1, 32'h0);
    chk(r, 32'h102);
    apb(1'b0, dss_pkg::OFS_ENDSTAT, 32'h0);
    chk(r, {16'h0, STAT_WORD});
    apb(1'b0, dss_pkg::OFS_FLAGS, 32'h0);
    chk(r, 32'h28);
    apb(1'b0, dss_pkg::OFS_IRQ_STAT, 32'h0);
    chk(r, 32'h1);
    chk({31'h0, IRQ_O}, 32'h0);
    apb(1'b1, dss_pkg::OFS_IRQ_MASK, 32'h3);
    @(posedge REF_CLK_I);
    chk({31'h0, IRQ_O}, 32'h1);
    // even channel start is refused and leaves the link resting
    apb(1'b1, dss_pkg::OFS_FUNC, 32'h0000_0001);
    apb(1'b0, dss_pkg::OFS_IRQ_STAT, 32'h0);
    chk(r, 32'h3);
    chk({31'h0, LINK_SLAVE_ACK_O}, 32'h1);
    apb(1'b1, dss_pkg::OFS_IRQ_STAT, 32'h3);
    @(posedge REF_CLK_I);
    chk({31'h0, IRQ_O}, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    chk({r[30:0], e}, 32'h1);
    // counter now zero: slow drive, straight to status, start while running
    slow <= 1'b1;
    apb(1'b1, dss_pkg::OFS_FUNC, 32'h0000_0101);
    apb(1'b1, dss_pkg::OFS_FUNC, 32'h0000_0101);
    rest();
    apb(1'b0, dss_pkg::OFS_IRQ_STAT, 32'h0);
    chk(r, 32'h3);
    chk(drv.words.size(), 32'h6);
    foreach (wexp[i]) chk({15'h0, drv.words[i]}, {15'h0, wexp[i]});
    // reset in mid-run
    apb(1'b1, dss_pkg::OFS_FUNC, 32'h0000_0101);
    SYS_RST_I <= 1'b1;
    @(posedge REF_CLK_I);
    chk({13'h0, LINK_O}, 32'h0);
    chk({31'h0, LINK_SLAVE_ACK_O}, 32'h0);
    SYS_RST_I <= 1'b0;
    apb(1'b0, dss_pkg::OFS_XFER_CNT, 32'h0);
    chk(r, 32'h0);
    summarize();
  end
endmodule
